/* File: phy_regs.v */
// Behaviour
// (RULE1) Phase value counts 4 ns delay steps from reference to transmit clock.
// (RULE2) Written phase values above ten are stored and applied modulo ten.
// (RULE3) New value moves transmit clock by 4 ns times the value difference.
// (RULE4) Phase is applied only when the self-clearing enable bit 4 is written.
// (RULE5) Bits 3:0 read back the current phase value, resetting to zero.
// (RULE6) Reserved phase and diagnostic bits ignore writes and read zero.
// (RULE7) Transmit clock keeps a fixed default phase until reprogrammed.
// (RULE8) Writing one to bit 15 powers down the internal regulator.
// (RULE9) Regulator stays powered and drives its output while not powered down.
// (RULE10) Software writes zeros to regulator control bits 14:4.
// (RULE11) Software ignores read of bits 3:0, writes after a read.
// (RULE12) Regulator power-down is used only with an external supply.
// (RULE13) Diagnostic start self-clears on run; done and result are read-only.
//
// Our own choice: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "phy_regs_defs.vh"

module phy_regs #(
  parameter PHASE_STEPS = 10
) (
  // Clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire        hready,
  input  wire [31:0] hwdata,
  output reg  [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  // Reference clock pin and transmit clock
  input  wire        ref_clock_in,
  output wire        tx_clk_out,
  // Voltage regulator
  output reg         regulator_power_down,
  output wire        regulator_output_pin,
  // Line diagnostic engine
  output reg         line_diag_start,
  output reg  [2:0]  line_diag_mode,
  input  wire        line_diag_done_in,
  input  wire [7:0]  line_diag_result_in
);

  // Address phase capture
  reg        wr_pend;
  reg [31:0] wr_addr;
  wire       access;
  wire       wr_req;
  wire       rd_req;

  // Register state
  reg [3:0]  phase_value;
  reg        phase_enable;
  reg        phase_apply;
  reg [10:0] reg_reserved;
  reg [3:0]  reg_ctl;
  reg        reg_pd_bit;
  reg        diag_start_bit;
  reg        diag_done;
  reg [7:0]  line_diag_result1;
  reg        diag_done_meta;
  reg        diag_done_sync;
  reg        diag_done_prev;
  reg [7:0]  result_meta;
  reg [7:0]  result_sync;

  // Write decode helpers
  reg         wr_phase;
  reg         wr_reg;
  reg         wr_diag;
  wire [3:0]  wr_value;
  reg  [3:0]  next_phase;
  reg  [31:0] next_rdata;
  wire        diag_done_rise;

  // Write data fields
  wire        wr_phase_en;
  wire [10:0] wr_reg_rsv;
  wire [3:0]  wr_reg_ctl;
  wire        wr_pd_req;
  wire [2:0]  wr_diag_mode;
  wire        wr_start_req;

  // Read words, one per register
  reg  [31:0] phase_word;
  reg  [31:0] reg_word;
  reg  [31:0] diag_word;

  // Zero-wait slave, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Valid transfer in the address phase
  assign access = hsel && hready && (htrans == `HTRANS_NONSEQ || htrans == `HTRANS_SEQ);
  assign wr_req = access && hwrite;
  assign rd_req = access && !hwrite;

  // Latch the write address for its data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 32'h0000_0000;
    end else if (hready) begin
      wr_pend <= wr_req;
      wr_addr <= wr_req ? haddr : 32'h0000_0000;
    end
  end

  // Data phase write strobes, one register per latched address
  always @* begin
    wr_phase = 1'b0;
    wr_reg   = 1'b0;
    wr_diag  = 1'b0;
    if (!wr_pend) begin
      wr_phase = 1'b0;
    end else if (wr_addr == `ADDR_TX_CLOCK_PHASE_SHIFT) begin
      wr_phase = 1'b1;
    end else if (wr_addr == `ADDR_REGULATOR_CONTROL) begin
      wr_reg = 1'b1;
    end else if (wr_addr == `ADDR_LINE_DIAG_CTRL_RES1) begin
      wr_diag = 1'b1;
    end
  end

  // Write data fields; the regulator reserved bits 14:4 are taken as written too
  assign wr_value     = hwdata[`PHASE_VALUE_MSB:`PHASE_VALUE_LSB];
  assign wr_phase_en  = hwdata[`PHASE_ENABLE_BIT];
  assign wr_reg_rsv   = hwdata[`REG_RSV_MSB:`REG_RSV_LSB];
  assign wr_reg_ctl   = hwdata[`REG_CTL_MSB:`REG_CTL_LSB];
  assign wr_pd_req    = hwdata[`REG_PD_BIT];
  assign wr_diag_mode = hwdata[`DIAG_CTRL_MSB:`DIAG_CTRL_LSB];
  assign wr_start_req = hwdata[`DIAG_START_BIT];

  // Fold values above ten back into range
  // A written ten stays ten, which the generator treats as zero steps
  always @* begin
    if (wr_value > `PHASE_WRAP) begin
      next_phase = wr_value - `PHASE_WRAP;    // [RULE2]
    end else begin
      next_phase = wr_value;
    end
  end

  // Phase shift register; enable self-clears after one cycle
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_value  <= `PHASE_VALUE_RST;      // [RULE5]
      phase_enable <= 1'b0;
      phase_apply  <= 1'b0;
    end else begin
      phase_apply <= 1'b0;
      if (phase_enable) begin
        phase_enable <= 1'b0;                // [RULE4]
      end
      if (wr_phase) begin
        phase_value <= next_phase;           // [RULE2]
        if (wr_phase_en) begin
          phase_enable <= 1'b1;
          phase_apply  <= 1'b1;              // [RULE4]
        end
      end
    end
  end

  // Regulator control value, stored and read back as written
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reg_reserved <= `REG_RSV_RST;
      reg_ctl      <= `REG_CTL_RST;
    end else if (wr_reg) begin
      reg_reserved <= wr_reg_rsv;
      reg_ctl      <= wr_reg_ctl;
    end
  end

  // Power-down request: the bit self-clears, the regulator stays off
  // until reset. Only boards with an external supply may use it; the
  // block cannot tell, so it simply obeys the write.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reg_pd_bit           <= 1'b0;
      regulator_power_down <= 1'b0;          // [RULE9]
    end else begin
      reg_pd_bit <= wr_reg && wr_pd_req;
      if (wr_reg && wr_pd_req) begin
        regulator_power_down <= 1'b1;        // [RULE8] [RULE12]
      end
    end
  end

  // Regulator output live only while powered
  assign regulator_output_pin = !regulator_power_down;  // [RULE9]

  // Two-stage synchroniser and edge detector for the done level
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      diag_done_meta <= 1'b0;
      diag_done_sync <= 1'b0;
      diag_done_prev <= 1'b0;
    end else begin
      diag_done_meta <= line_diag_done_in;
      diag_done_sync <= diag_done_meta;
      diag_done_prev <= diag_done_sync;
    end
  end

  // Result bus through two stages; it is only taken at the done edge
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      result_meta <= `DIAG_RES_RST;
      result_sync <= `DIAG_RES_RST;
    end else begin
      result_meta <= line_diag_result_in;
      result_sync <= result_meta;
    end
  end

  assign diag_done_rise = diag_done_sync && !diag_done_prev;

  // Diagnostic control: mode, start bit and one-cycle start pulse
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      diag_start_bit  <= 1'b0;
      line_diag_start <= 1'b0;
      line_diag_mode  <= `DIAG_CTRL_RST;
    end else begin
      diag_start_bit  <= wr_diag && wr_start_req;  // [RULE13]
      line_diag_start <= wr_diag && wr_start_req;
      if (wr_diag) begin
        line_diag_mode <= wr_diag_mode;
      end
    end
  end

  // Sticky done and captured result; a done edge beats a new start
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      diag_done         <= 1'b0;
      line_diag_result1 <= `DIAG_RES_RST;
    end else if (diag_done_rise) begin
      diag_done         <= 1'b1;             // [RULE13]
      line_diag_result1 <= result_sync;
    end else if (wr_diag && wr_start_req) begin
      diag_done <= 1'b0;
    end
  end

  // Phase word: value and one-cycle enable, reserved bits zero
  always @* begin
    phase_word = 32'h0000_0000;
    phase_word[`PHASE_ENABLE_BIT] = phase_enable;
    phase_word[`PHASE_VALUE_MSB:`PHASE_VALUE_LSB] = phase_value;  // [RULE5] [RULE6]
  end

  // Regulator word: self-clearing power-down bit and stored fields
  always @* begin
    reg_word = 32'h0000_0000;
    reg_word[`REG_PD_BIT] = reg_pd_bit;
    reg_word[`REG_RSV_MSB:`REG_RSV_LSB] = reg_reserved;
    reg_word[`REG_CTL_MSB:`REG_CTL_LSB] = reg_ctl;
  end

  // Diagnostic word: start, done, result and mode, reserved bits zero
  always @* begin
    diag_word = 32'h0000_0000;
    diag_word[`DIAG_START_BIT] = diag_start_bit;
    diag_word[`DIAG_DONE_BIT] = diag_done;
    diag_word[`DIAG_RES_MSB:`DIAG_RES_LSB] = line_diag_result1;  // [RULE6]
    diag_word[`DIAG_CTRL_MSB:`DIAG_CTRL_LSB] = line_diag_mode;
  end

  // Read mux on the address phase; unmapped addresses read zero
  always @* begin
    next_rdata = 32'h0000_0000;
    if (haddr == `ADDR_TX_CLOCK_PHASE_SHIFT) begin
      next_rdata = phase_word;
    end else if (haddr == `ADDR_REGULATOR_CONTROL) begin
      next_rdata = reg_word;
    end else if (haddr == `ADDR_LINE_DIAG_CTRL_RES1) begin
      next_rdata = diag_word;
    end else begin
      next_rdata = 32'h0000_0000;
    end
  end

  // Read data registered for the data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_req) begin
      hrdata <= next_rdata;
    end
  end

  // Transmit clock generator
  tx_phase_gen #(
    .STEPS (PHASE_STEPS)
  ) u_tx_phase_gen (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .ref_clock_in (ref_clock_in),
    .apply        (phase_apply),
    .offset       (phase_value),
    .tx_clk_out   (tx_clk_out)
  );

endmodule
`default_nettype wire

/* File: phy_regs_defs.vh */
`ifndef PHY_REGS_DEFS_VH
`define PHY_REGS_DEFS_VH

// Register indices; byte address is four times the index
`define IDX_TX_CLOCK_PHASE_SHIFT 12'h042
`define IDX_REGULATOR_CONTROL    12'h0d0
`define IDX_LINE_DIAG_CTRL_RES1  12'h155
`define ADDR_TX_CLOCK_PHASE_SHIFT 32'h0000_0108
`define ADDR_REGULATOR_CONTROL    32'h0000_0340
`define ADDR_LINE_DIAG_CTRL_RES1  32'h0000_0554

// Phase shift register fields
`define PHASE_VALUE_MSB  3
`define PHASE_VALUE_LSB  0
`define PHASE_ENABLE_BIT 4
`define PHASE_VALUE_RST  4'h0
`define PHASE_WRAP       4'ha

// Regulator control fields
`define REG_PD_BIT       15
`define REG_RSV_MSB      14
`define REG_RSV_LSB      4
`define REG_CTL_MSB      3
`define REG_CTL_LSB      0
`define REG_RSV_RST      11'h000
`define REG_CTL_RST      4'h0

// Line diagnostic fields
`define DIAG_START_BIT   15
`define DIAG_DONE_BIT    12
`define DIAG_RES_MSB     11
`define DIAG_RES_LSB     4
`define DIAG_CTRL_MSB    2
`define DIAG_CTRL_LSB    0
`define DIAG_CTRL_RST    3'h0
`define DIAG_RES_RST     8'h00

// Timing: one phase step and the system clock period, both in ps
`define PHASE_STEP_PS    4000
`define HCLK_PERIOD_PS   4000
`define STEP_CYCLES      ((`PHASE_STEP_PS + `HCLK_PERIOD_PS - 1) / `HCLK_PERIOD_PS)

// AHB transfer types
`define HTRANS_NONSEQ    2'b10
`define HTRANS_SEQ       2'b11

`endif

/* File: tx_phase_gen.v */
`timescale 1ns/10ps
`default_nettype none
`include "phy_regs_defs.vh"

module tx_phase_gen #(
  parameter STEPS = 10
) (
  // Clock and reset
  input  wire       hclk,
  input  wire       hresetn,
  // Reference clock pin, asynchronous
  input  wire       ref_clock_in,
  // Phase control
  input  wire       apply,
  input  wire [3:0] offset,
  // Generated transmit clock
  output reg        tx_clk_out
);

  // Step constants, cut to the counter width on purpose
  localparam [31:0] LAST_W  = STEPS - 1;
  localparam [31:0] HALF_W  = STEPS / 2;
  localparam [31:0] NSTEP_W = STEPS;
  localparam [3:0]  LAST    = LAST_W[3:0];
  localparam [3:0]  HALF    = HALF_W[3:0];
  localparam [3:0]  NSTEP   = NSTEP_W[3:0];

  reg       ref_meta;
  reg       ref_sync;
  reg       ref_prev;
  reg [3:0] ref_cnt;
  reg [3:0] applied;
  reg [3:0] next_tap;

  // Two-stage synchroniser for the reference pin
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ref_meta <= 1'b0;
      ref_sync <= 1'b0;
      ref_prev <= 1'b0;
    end else begin
      ref_meta <= ref_clock_in;
      ref_sync <= ref_meta;
      ref_prev <= ref_sync;
    end
  end

  // Step counter, one 4 ns step per clock, aligned to reference rising edge
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ref_cnt <= 4'h0;
    end else if (ref_sync && !ref_prev) begin
      ref_cnt <= 4'h1;
    end else if (ref_cnt == LAST) begin
      ref_cnt <= 4'h0;
    end else begin
      ref_cnt <= ref_cnt + 4'h1;
    end
  end

  // Offset held until an explicit apply; default phase is zero steps
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      applied <= 4'h0;                       // [RULE7]
    end else if (apply) begin
      applied <= offset;                     // [RULE4]
    end
  end

  // Delayed tap: reference step minus offset, modulo the step count
  always @* begin
    if (ref_cnt >= applied) begin
      next_tap = ref_cnt - applied;          // [RULE1]
    end else begin
      next_tap = ref_cnt + NSTEP - applied;  // [RULE1]
    end
  end

  // Transmit clock high for the first half of its period
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_clk_out <= 1'b0;
    end else begin
      tx_clk_out <= (next_tap < HALF);       // [RULE3]
    end
  end

endmodule
`default_nettype wire

/* File: phy_regs_sva.sv */
`timescale 1ns/10ps
`default_nettype none
`include "phy_regs_defs.vh"
module phy_regs_sva (
  // Bus
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Side outputs
  input wire logic        regulator_power_down,
  input wire logic        regulator_output_pin,
  input wire logic        line_diag_start,
  input wire logic [2:0]  line_diag_mode
);
  wire  take = hsel && hready && htrans[1];
  logic rd_ph;
  logic wr_rg;
  logic wr_dg;
  // Remember which register the pending data phase targets
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_ph <= 1'b0;
      wr_rg <= 1'b0;
      wr_dg <= 1'b0;
    end else begin
      rd_ph <= take && !hwrite && haddr == `ADDR_TX_CLOCK_PHASE_SHIFT;
      wr_rg <= take && hwrite && haddr == `ADDR_REGULATOR_CONTROL;
      wr_dg <= take && hwrite && haddr == `ADDR_LINE_DIAG_CTRL_RES1;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_READY: assert property (hreadyout)
    else $error("hreadyout low");
  AST_OKAY: assert property (!hresp)
    else $error("hresp not okay");
  AST_VR_PIN: assert property (regulator_output_pin == !regulator_power_down)
    else $error("regulator pin disagrees with power down");
  AST_PD_HOLD: assert property (!$fell(regulator_power_down))
    else $error("power down released");
  AST_PD_CAUSE: assert property ($rose(regulator_power_down) |->
    $past(wr_rg && hwdata[15]) || $past(wr_rg && hwdata[15], 2))
    else $error("power down without write");
  AST_START_ONE: assert property (line_diag_start |=> !line_diag_start)
    else $error("start pulse too long");
  AST_START_CAUSE: assert property (line_diag_start |->
    $past(wr_dg && hwdata[15]) || $past(wr_dg && hwdata[15], 2))
    else $error("start without write");
  AST_MODE: assert property (!$stable(line_diag_mode) |-> $past(wr_dg) || $past(wr_dg, 2))
    else $error("mode changed without write");
  AST_RSV_ZERO: assert property (rd_ph |-> hrdata[31:5] == 27'h0)
    else $error("reserved phase bits not zero");
  AST_MOD10: assert property (rd_ph |-> hrdata[3:0] <= 4'ha)
    else $error("phase value above ten");
endmodule
bind phy_regs phy_regs_sva i_phy_regs_sva (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hready, .hwdata, .hrdata, .hreadyout, .hresp, .regulator_power_down,
  .regulator_output_pin, .line_diag_start, .line_diag_mode);
`default_nettype wire

/* File: phy_regs_bench.sv */
`timescale 1ns/10ps
`default_nettype none
`include "phy_regs_defs.vh"
module phy_regs_bench;
  // Stimulus and observed outputs
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        ref_clock_in = 1'b0;
  logic        done_in = 1'b0;
  logic [7:0]  res_in = 8'h00;
  logic [31:0] rd;
  wire  [31:0] hrdata;
  wire         hreadyout;
  wire         hresp;
  wire         tx_clk;
  wire         vr_pd;
  wire         vr_pin;
  wire         d_start;
  wire  [2:0]  d_mode;
  int          n_mismatch = 0;
  int          total_checks = 0;
  int          n_start = 0;
  int          o0, o1, o2;

  phy_regs #(.PHASE_STEPS(10)) i_phy_regs (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .ref_clock_in(ref_clock_in), .tx_clk_out(tx_clk), .regulator_power_down(vr_pd),
    .regulator_output_pin(vr_pin), .line_diag_start(d_start), .line_diag_mode(d_mode),
    .line_diag_done_in(done_in), .line_diag_result_in(res_in));

  // Bus clock and a 40 ns reference clock off the bus edges
  initial forever #2 hclk = ~hclk;
  initial begin
    #1;
    forever #20 ref_clock_in = ~ref_clock_in;
  end
  // Count start pulses
  always @(posedge hclk) if (d_start === 1'b1) n_start++;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One single transfer, then an idle cycle
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    @(posedge hclk);
  endtask
  task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0);
    chk(rd, exp);
  endtask
  // Delay from a reference rise to the next transmit clock rise
  task automatic phase(output int o);
    realtime t;
    repeat (30) @(posedge hclk);
    @(posedge ref_clock_in);
    t = $realtime;
    @(posedge tx_clk);
    o = int'($realtime - t) % 40;
    @(posedge hclk);
  endtask

  task automatic t_reset();
    rdchk(`ADDR_TX_CLOCK_PHASE_SHIFT, 32'h0);
    rdchk(`ADDR_LINE_DIAG_CTRL_RES1, 32'h0);
    chk(vr_pin, 1'b1);
    chk(vr_pd, 1'b0);
  endtask
  task automatic t_phase();
    phase(o0);
    phase(o1);
    chk(o1, o0);
    xfer(`ADDR_TX_CLOCK_PHASE_SHIFT, 1'b1, 32'h12);
    phase(o1);
    chk((o1 - o0 + 40) % 40, 8);
    rdchk(`ADDR_TX_CLOCK_PHASE_SHIFT, 32'h2);
    xfer(`ADDR_TX_CLOCK_PHASE_SHIFT, 1'b1, 32'h19);
    phase(o2);
    chk((o2 - o1 + 40) % 40, 28);
    xfer(`ADDR_TX_CLOCK_PHASE_SHIFT, 1'b1, 32'h04);
    phase(o1);
    chk(o1, o2);
    for (int v = 10; v < 16; v++) begin
      xfer(`ADDR_TX_CLOCK_PHASE_SHIFT, 1'b1, 32'hfff0 | v);
      rdchk(`ADDR_TX_CLOCK_PHASE_SHIFT, (v > 10) ? v - 10 : v);
    end
    phase(o1);
    chk((o1 - o0 + 40) % 40, 20);
  endtask
  // Read before each regulator write, reserved bits kept zero
  task automatic t_reg();
    rdchk(`ADDR_REGULATOR_CONTROL, 32'h0);
    xfer(`ADDR_REGULATOR_CONTROL, 1'b1, 32'h0005);
    chk({vr_pd, vr_pin}, 2'b01);
    rdchk(`ADDR_REGULATOR_CONTROL, 32'h5);
    xfer(`ADDR_REGULATOR_CONTROL, 1'b1, 32'h8005);
    chk({vr_pd, vr_pin}, 2'b10);
    rdchk(`ADDR_REGULATOR_CONTROL, 32'h5);
    xfer(`ADDR_REGULATOR_CONTROL, 1'b1, 32'h0005);
    chk(vr_pd, 1'b1);
    xfer(32'h200, 1'b1, 32'hffff);
    rdchk(32'h200, 32'h0);
  endtask
  task automatic t_diag();
    int n;
    for (int m = 0; m < 8; m++) begin
      xfer(`ADDR_LINE_DIAG_CTRL_RES1, 1'b1, 32'h6008 | m);
      chk(d_mode, m);
      rdchk(`ADDR_LINE_DIAG_CTRL_RES1, m);
    end
    n = n_start;
    xfer(`ADDR_LINE_DIAG_CTRL_RES1, 1'b1, 32'h8003);
    @(posedge hclk);
    chk(n_start - n, 1);
    res_in <= 8'ha5;
    done_in <= 1'b1;
    repeat (3) @(posedge hclk);
    done_in <= 1'b0;
    repeat (4) @(posedge hclk);
    rdchk(`ADDR_LINE_DIAG_CTRL_RES1, 32'h1a53);
    xfer(`ADDR_LINE_DIAG_CTRL_RES1, 1'b1, 32'h8003);
    rdchk(`ADDR_LINE_DIAG_CTRL_RES1, 32'h0a53);
  endtask

  task automatic conclude();
    if (n_mismatch == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_phase();
    t_reg();
    t_diag();
    conclude();
  end
  // Watchdog
  initial begin
    #100000;
    n_mismatch++;
    conclude();
  end
endmodule
`default_nettype wire
